// File: verilog/pss_pkg.sv
// Operation
// - the summary register answers at management index 0x10
// - bit 15 ignores writes and always reads zero
// - bit 14 shows crossover: one means pairs swapped, zero means normal
// - crossover bit follows enable and force; live when enabled and not forced
// - bit 13 latches receive errors until receive error count register is read
// - bit 12 mirrors polarity bit 4, cleared only by reading the 10BASE-T register
// - bit 11 latches false carrier until false carrier count register is read
// - bit 10 is latch-low signal detect, so a loss stays visible
// - bit 9 is latch-low descrambler lock, so a lost lock stays recorded
// - bit 8 mirrors page received, cleared only by reading the expansion register
// - bit 7 reads one while an interrupt is pending; event register read clears it
// - bit 6 latches remote fault; basic status read or reset clears it
package pss_pkg;

	// ****************************************
	// bus geometry
	// ****************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int REG_W  = 16;
	localparam int IDX_W  = 6;

	// ****************************************
	// register indices (byte address is four times the index)
	// ****************************************
	localparam logic [IDX_W-1:0] IDX_BASIC_STATUS   = 6'h01;
	localparam logic [IDX_W-1:0] IDX_AN_EXPANSION   = 6'h06;
	localparam logic [IDX_W-1:0] IDX_STATUS_SUMMARY = 6'h10;
	localparam logic [IDX_W-1:0] IDX_INT_EVENT      = 6'h12;
	localparam logic [IDX_W-1:0] IDX_FALSE_CARRIER  = 6'h14;
	localparam logic [IDX_W-1:0] IDX_RX_ERROR       = 6'h15;
	localparam logic [IDX_W-1:0] IDX_TENBASE        = 6'h1C;
	localparam logic [IDX_W-1:0] IDX_CONTROL        = 6'h1D;
	localparam logic [IDX_W-1:0] IDX_IRQ_STATUS     = 6'h1E;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK       = 6'h1F;

	// ****************************************
	// summary field positions
	// ****************************************
	localparam int SUM_RESERVED  = 15;
	localparam int SUM_CROSSOVER = 14;
	localparam int SUM_RX_ERROR  = 13;
	localparam int SUM_POLARITY  = 12;
	localparam int SUM_FALSE_CAR = 11;
	localparam int SUM_SIG_DET   = 10;
	localparam int SUM_DESC_LOCK = 9;
	localparam int SUM_PAGE_RX   = 8;
	localparam int SUM_INT_PEND  = 7;
	localparam int SUM_REM_FAULT = 6;
	localparam int TENBASE_POLARITY = 4;
	localparam int EXPANSION_PAGE   = 1;

	// ****************************************
	// sticky latch slots
	// ****************************************
	localparam int LAT_N         = 8;
	localparam int LAT_RX_ERROR  = 0;
	localparam int LAT_FALSE_CAR = 1;
	localparam int LAT_POLARITY  = 2;
	localparam int LAT_PAGE_RX   = 3;
	localparam int LAT_INT_PEND  = 4;
	localparam int LAT_REM_FAULT = 5;
	localparam int LAT_SIG_LOSS  = 6;
	localparam int LAT_LOCK_LOSS = 7;

	// ****************************************
	// control and interrupt layout
	// ****************************************
	localparam int CTL_AUTO_XOVER = 0;
	localparam int CTL_XOVER_FORCE = 1;
	localparam int IRQ_N          = 6;
	localparam int IRQ_RX_ERROR   = 0;
	localparam int IRQ_FALSE_CAR  = 1;
	localparam int IRQ_PAGE_RX    = 2;
	localparam int IRQ_REM_FAULT  = 3;
	localparam int IRQ_SIG_LOSS   = 4;
	localparam int IRQ_LOCK_LOSS  = 5;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [REG_W-1:0] RST_CONTROL  = 16'h0000;
	localparam logic [IRQ_N-1:0] RST_IRQ_MASK = 6'h00;
	localparam logic [LAT_N-1:0] RST_LATCHES  = 8'h00;

	// ****************************************
	// bus handshake states
	// ****************************************
	typedef enum logic [0:0] {
		PSS_IDLE = 1'b0,
		PSS_DONE = 1'b1
	} pss_bus_state_t;

endpackage : pss_pkg

// File: verilog/pss_sync3.sv
`timescale 1ns/1ps
module pss_sync3 #(
	parameter int WIDTH = 2
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             reset,
	input  wire logic             clk_en,
	// asynchronous levels in, filtered levels out
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	// ****************************************
	// per-bit three stage synchroniser
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			logic stage1_q;
			logic stage2_q;
			logic stage3_q;
			logic level_q;
			always_ff @(posedge core_clk) begin
				if (reset) begin
					stage1_q <= 1'b0;
					stage2_q <= 1'b0;
					stage3_q <= 1'b0;
					level_q  <= 1'b0;
				end else if (clk_en) begin
					stage1_q <= async_in[g];
					stage2_q <= stage1_q;
					stage3_q <= stage2_q;
					// only accept a level once two settled stages agree
					if (stage2_q == stage3_q) begin
						level_q <= stage3_q;
					end
				end
			end
			assign sync_out[g] = level_q;
		end
	endgenerate

endmodule : pss_sync3

// File: verilog/pss_sticky.sv
`timescale 1ns/1ps
module pss_sticky #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             reset,
	input  wire logic             clk_en,
	// per-bit set and clear
	input  wire logic [WIDTH-1:0] set_in,
	input  wire logic [WIDTH-1:0] clr_in,
	output logic      [WIDTH-1:0] flag_q
);

	// ****************************************
	// set dominates clear, so no event is lost
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_flag
			always_ff @(posedge core_clk) begin
				if (reset) begin
					flag_q[g] <= 1'b0;
				end else if (clk_en) begin
					flag_q[g] <= set_in[g] | (flag_q[g] & ~clr_in[g]);
				end
			end
		end
	endgenerate

endmodule : pss_sticky

// File: verilog/pss_status_summary.sv
`timescale 1ns/1ps
module pss_status_summary (
	// clock, reset, enable
	input  wire logic                        core_clk,
	input  wire logic                        reset,
	input  wire logic                        clk_en,
	// avalon-mm slave
	input  wire logic [pss_pkg::ADDR_W-1:0]  avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire logic [pss_pkg::DATA_W-1:0]  avs_writedata,
	input  wire logic [3:0]                  avs_byteenable,
	output logic      [pss_pkg::DATA_W-1:0]  avs_readdata,
	output logic                             avs_waitrequest,
	// same-clock events and levels from the phy core
	input  wire logic                        rx_error_event,
	input  wire logic                        false_carrier_event,
	input  wire logic                        polarity_inverted,
	input  wire logic                        page_received_event,
	input  wire logic                        interrupt_event,
	input  wire logic                        remote_fault_event,
	input  wire logic                        crossover_auto_state,
	// levels from the medium-dependent sublayer, other clock
	input  wire logic                        signal_detect,
	input  wire logic                        descrambler_lock,
	// interrupt
	output logic                             irq
);

	// ****************************************
	// bus handshake
	// ****************************************
	pss_pkg::pss_bus_state_t     bus_state_q;
	pss_pkg::pss_bus_state_t     bus_state_d;
	logic                        req;
	logic                        rd_take;
	logic                        wr_take;
	logic [pss_pkg::IDX_W-1:0]   idx;

	assign req = avs_read | avs_write;
	assign idx = avs_address[pss_pkg::ADDR_W-1:2];
	// one wait cycle: data is captured in idle, handed over in done
	// a frozen enable keeps the master waiting, so no write is lost in done
	assign avs_waitrequest = req & ((bus_state_q == pss_pkg::PSS_IDLE) | ~clk_en);
	assign rd_take = clk_en & avs_read & (bus_state_q == pss_pkg::PSS_IDLE);
	assign wr_take = clk_en & avs_write & (bus_state_q == pss_pkg::PSS_DONE);

	always_comb begin
		bus_state_d = bus_state_q;
		case (bus_state_q)
			pss_pkg::PSS_IDLE: begin
				if (req) begin
					bus_state_d = pss_pkg::PSS_DONE;
				end
			end
			pss_pkg::PSS_DONE: begin
				bus_state_d = pss_pkg::PSS_IDLE;
			end
			default: begin
				bus_state_d = pss_pkg::PSS_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			bus_state_q <= pss_pkg::PSS_IDLE;
		end else if (clk_en) begin
			bus_state_q <= bus_state_d;
		end
	end

	// ****************************************
	// clear-on-read strobes
	// ****************************************
	// strobes fire at the capture edge so the returned value and the clear agree
	logic rd_summary;
	logic rd_rx_error;
	logic rd_false_car;
	logic rd_tenbase;
	logic rd_expansion;
	logic rd_int_event;
	logic rd_basic;

	assign rd_summary   = rd_take & (idx == pss_pkg::IDX_STATUS_SUMMARY);
	assign rd_rx_error  = rd_take & (idx == pss_pkg::IDX_RX_ERROR);
	assign rd_false_car = rd_take & (idx == pss_pkg::IDX_FALSE_CARRIER);
	assign rd_tenbase   = rd_take & (idx == pss_pkg::IDX_TENBASE);
	assign rd_expansion = rd_take & (idx == pss_pkg::IDX_AN_EXPANSION);
	assign rd_int_event = rd_take & (idx == pss_pkg::IDX_INT_EVENT);
	assign rd_basic     = rd_take & (idx == pss_pkg::IDX_BASIC_STATUS);

	// ****************************************
	// medium-dependent levels
	// ****************************************
	logic [1:0] pmd_sync;
	logic       sig_det_s;
	logic       lock_s;
	logic       sig_det_prev_q;
	logic       lock_prev_q;

	pss_sync3 #(
		.WIDTH (2)
	) u_pmd_sync (
		.core_clk (core_clk),
		.reset    (reset),
		.clk_en   (clk_en),
		.async_in ({descrambler_lock, signal_detect}),
		.sync_out (pmd_sync)
	);

	assign sig_det_s = pmd_sync[0];
	assign lock_s    = pmd_sync[1];

	// previous levels feed the falling-edge interrupts; both reset low like the
	// synchroniser, so a pin already low at release raises no false edge

	always_ff @(posedge core_clk) begin
		if (reset) begin
			sig_det_prev_q <= 1'b0;
			lock_prev_q    <= 1'b0;
		end else if (clk_en) begin
			sig_det_prev_q <= sig_det_s;
			lock_prev_q    <= lock_s;
		end
	end

	// ****************************************
	// status latches
	// ****************************************
	logic [pss_pkg::LAT_N-1:0] lat_set;
	logic [pss_pkg::LAT_N-1:0] lat_clr;
	logic [pss_pkg::LAT_N-1:0] lat_q;

	// limitation: a source held high re-sets its latch every cycle, so a
	// clearing read only sticks once the source has gone quiet

	always_comb begin
		lat_set = '0;
		lat_clr = '0;
		lat_set[pss_pkg::LAT_RX_ERROR]  = rx_error_event;
		lat_clr[pss_pkg::LAT_RX_ERROR]  = rd_rx_error;
		lat_set[pss_pkg::LAT_FALSE_CAR] = false_carrier_event;
		lat_clr[pss_pkg::LAT_FALSE_CAR] = rd_false_car;
		lat_set[pss_pkg::LAT_POLARITY]  = polarity_inverted;
		lat_clr[pss_pkg::LAT_POLARITY]  = rd_tenbase;
		lat_set[pss_pkg::LAT_PAGE_RX]   = page_received_event;
		lat_clr[pss_pkg::LAT_PAGE_RX]   = rd_expansion;
		lat_set[pss_pkg::LAT_INT_PEND]  = interrupt_event;
		lat_clr[pss_pkg::LAT_INT_PEND]  = rd_int_event;
		lat_set[pss_pkg::LAT_REM_FAULT] = remote_fault_event;
		lat_clr[pss_pkg::LAT_REM_FAULT] = rd_basic;
		// latch-low: a loss is held until the summary itself is read
		lat_set[pss_pkg::LAT_SIG_LOSS]  = ~sig_det_s;
		lat_clr[pss_pkg::LAT_SIG_LOSS]  = rd_summary;
		lat_set[pss_pkg::LAT_LOCK_LOSS] = ~lock_s;
		lat_clr[pss_pkg::LAT_LOCK_LOSS] = rd_summary;
	end

	pss_sticky #(
		.WIDTH (pss_pkg::LAT_N)
	) u_latches (
		.core_clk (core_clk),
		.reset    (reset),
		.clk_en   (clk_en),
		.set_in   (lat_set),
		.clr_in   (lat_clr),
		.flag_q   (lat_q)
	);

	// ****************************************
	// control register and crossover state
	// ****************************************
	logic [pss_pkg::REG_W-1:0] control_q;
	logic                      crossover_q;

	// registered, so the bit trails the live auto state by one cycle

	always_ff @(posedge core_clk) begin
		if (reset) begin
			control_q <= pss_pkg::RST_CONTROL;
		end else if (wr_take && idx == pss_pkg::IDX_CONTROL) begin
			if (avs_byteenable[0]) begin
				control_q[7:0] <= avs_writedata[7:0];
			end
			if (avs_byteenable[1]) begin
				control_q[15:8] <= avs_writedata[15:8];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			crossover_q <= 1'b0;
		end else if (clk_en) begin
			if (control_q[pss_pkg::CTL_XOVER_FORCE]) begin
				crossover_q <= 1'b1;
			end else if (control_q[pss_pkg::CTL_AUTO_XOVER]) begin
				crossover_q <= crossover_auto_state;
			end else begin
				crossover_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// summary word
	// ****************************************
	logic [pss_pkg::REG_W-1:0] summary;

	// bits 5 to 0 belong to another block and read as zero here

	always_comb begin
		summary = '0;
		summary[pss_pkg::SUM_RESERVED]  = 1'b0;
		summary[pss_pkg::SUM_CROSSOVER] = crossover_q;
		summary[pss_pkg::SUM_RX_ERROR]  = lat_q[pss_pkg::LAT_RX_ERROR];
		summary[pss_pkg::SUM_POLARITY]  = lat_q[pss_pkg::LAT_POLARITY];
		summary[pss_pkg::SUM_FALSE_CAR] = lat_q[pss_pkg::LAT_FALSE_CAR];
		summary[pss_pkg::SUM_SIG_DET]   = sig_det_s & ~lat_q[pss_pkg::LAT_SIG_LOSS];
		summary[pss_pkg::SUM_DESC_LOCK] = lock_s & ~lat_q[pss_pkg::LAT_LOCK_LOSS];
		summary[pss_pkg::SUM_PAGE_RX]   = lat_q[pss_pkg::LAT_PAGE_RX];
		summary[pss_pkg::SUM_INT_PEND]  = lat_q[pss_pkg::LAT_INT_PEND];
		summary[pss_pkg::SUM_REM_FAULT] = lat_q[pss_pkg::LAT_REM_FAULT];
	end

	// ****************************************
	// interrupt status and mask
	// ****************************************
	logic [pss_pkg::IRQ_N-1:0] irq_set;
	logic [pss_pkg::IRQ_N-1:0] irq_clr;
	logic [pss_pkg::IRQ_N-1:0] irq_status_q;
	logic [pss_pkg::IRQ_N-1:0] irq_mask_q;

	// a one written to clear loses to an event in the same cycle

	always_comb begin
		irq_set = '0;
		irq_set[pss_pkg::IRQ_RX_ERROR]  = rx_error_event;
		irq_set[pss_pkg::IRQ_FALSE_CAR] = false_carrier_event;
		irq_set[pss_pkg::IRQ_PAGE_RX]   = page_received_event;
		irq_set[pss_pkg::IRQ_REM_FAULT] = remote_fault_event;
		irq_set[pss_pkg::IRQ_SIG_LOSS]  = sig_det_prev_q & ~sig_det_s;
		irq_set[pss_pkg::IRQ_LOCK_LOSS] = lock_prev_q & ~lock_s;
		irq_clr = '0;
		if (wr_take && idx == pss_pkg::IDX_IRQ_STATUS && avs_byteenable[0]) begin
			irq_clr = avs_writedata[pss_pkg::IRQ_N-1:0];
		end
	end

	pss_sticky #(
		.WIDTH (pss_pkg::IRQ_N)
	) u_irq_status (
		.core_clk (core_clk),
		.reset    (reset),
		.clk_en   (clk_en),
		.set_in   (irq_set),
		.clr_in   (irq_clr),
		.flag_q   (irq_status_q)
	);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			irq_mask_q <= pss_pkg::RST_IRQ_MASK;
		end else if (wr_take && idx == pss_pkg::IDX_IRQ_MASK && avs_byteenable[0]) begin
			irq_mask_q <= avs_writedata[pss_pkg::IRQ_N-1:0];
		end
	end

	assign irq = |(irq_status_q & irq_mask_q);

	// ****************************************
	// read data
	// ****************************************
	// source registers other than the summary live elsewhere; only the
	// mirrored bits are returned here, the rest read as zero
	// the other indices still clear their latches through the strobes above
	logic [pss_pkg::REG_W-1:0] rd_word;

	always_comb begin
		rd_word = '0;
		if (idx == pss_pkg::IDX_STATUS_SUMMARY) begin
			rd_word = summary;
		end else if (idx == pss_pkg::IDX_TENBASE) begin
			rd_word[pss_pkg::TENBASE_POLARITY] = lat_q[pss_pkg::LAT_POLARITY];
		end else if (idx == pss_pkg::IDX_AN_EXPANSION) begin
			rd_word[pss_pkg::EXPANSION_PAGE] = lat_q[pss_pkg::LAT_PAGE_RX];
		end else if (idx == pss_pkg::IDX_CONTROL) begin
			rd_word = control_q;
		end else if (idx == pss_pkg::IDX_IRQ_STATUS) begin
			rd_word[pss_pkg::IRQ_N-1:0] = irq_status_q;
		end else if (idx == pss_pkg::IDX_IRQ_MASK) begin
			rd_word[pss_pkg::IRQ_N-1:0] = irq_mask_q;
		end else begin
			rd_word = '0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			avs_readdata <= '0;
		end else if (rd_take) begin
			avs_readdata <= {16'h0000, rd_word};
		end
	end

endmodule : pss_status_summary

// File: tb/pss_status_summary_checker.sv
`timescale 1ns/1ps
module pss_status_summary_checker (
	// clock and reset
	input wire logic                       core_clk,
	input wire logic                       reset,
	input wire logic                       clk_en,
	// register bus
	input wire logic [pss_pkg::ADDR_W-1:0] avs_address,
	input wire logic                       avs_read,
	input wire logic                       avs_write,
	input wire logic [pss_pkg::DATA_W-1:0] avs_readdata,
	input wire logic                       avs_waitrequest,
	// status sources
	input wire logic                       rx_error_event,
	input wire logic                       false_carrier_event,
	input wire logic                       polarity_inverted,
	input wire logic                       page_received_event,
	input wire logic                       interrupt_event,
	input wire logic                       remote_fault_event,
	input wire logic                       signal_detect,
	input wire logic                       descrambler_lock,
	input wire logic                       irq
);
	wire logic sum_cap;

	// capture edge of a summary read
	assign sum_cap = avs_read && avs_waitrequest && clk_en &&
		(avs_address[7:2] == pss_pkg::IDX_STATUS_SUMMARY);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	// ****
	// bus handshake, reserved bits and reset
	// ****
	property p_wait_one;
		(avs_read || avs_write) && avs_waitrequest && clk_en |=> !avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one)
		else $error("request not answered after one wait cycle");
	property p_wait_once;
		(avs_read || avs_write) && !avs_waitrequest && clk_en |=>
			avs_waitrequest || !(avs_read || avs_write);
	endproperty
	a_wait_once: assert property (p_wait_once)
		else $error("waitrequest low for more than one cycle");
	property p_reserved;
		sum_cap |=> avs_readdata[31:15] == 17'h00000;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved summary bit read as one");
	property p_reset;
		$fell(reset) |-> avs_readdata == 32'h00000000 && !irq;
	endproperty
	a_reset: assert property (p_reset)
		else $error("outputs not cleared by reset");

	// ****
	// latched bits
	// ****
	property p_rx;
		sum_cap && $past(rx_error_event) |=> avs_readdata[pss_pkg::SUM_RX_ERROR];
	endproperty
	a_rx: assert property (p_rx)
		else $error("receive error not latched");
	property p_fc;
		false_carrier_event ##1 sum_cap |=> avs_readdata[pss_pkg::SUM_FALSE_CAR];
	endproperty
	a_fc: assert property (p_fc)
		else $error("false carrier not latched");
	property p_pol;
		polarity_inverted ##1 sum_cap |=> avs_readdata[pss_pkg::SUM_POLARITY];
	endproperty
	a_pol: assert property (p_pol)
		else $error("polarity not reported");
	property p_page;
		sum_cap && $past(page_received_event) |=> avs_readdata[pss_pkg::SUM_PAGE_RX] == 1'b1;
	endproperty
	a_page: assert property (p_page)
		else $error("page received not reported");
	property p_int;
		interrupt_event ##1 sum_cap |=> avs_readdata[pss_pkg::SUM_INT_PEND];
	endproperty
	a_int: assert property (p_int)
		else $error("interrupt pending not reported");
	property p_rf;
		sum_cap && $past(remote_fault_event) |=> avs_readdata[pss_pkg::SUM_REM_FAULT];
	endproperty
	a_rf: assert property (p_rf)
		else $error("remote fault not reported");
	property p_sig;
		(!signal_detect)[*8] ##0 sum_cap |=> !avs_readdata[pss_pkg::SUM_SIG_DET];
	endproperty
	a_sig: assert property (p_sig)
		else $error("signal detect high while input low");
	property p_lock;
		(!descrambler_lock)[*8] ##0 sum_cap |=> !avs_readdata[pss_pkg::SUM_DESC_LOCK];
	endproperty
	a_lock: assert property (p_lock)
		else $error("descrambler lock high while input low");

	c_sum: cover property (sum_cap);
	c_irq: cover property ($rose(irq));
	c_wr: cover property (avs_write && !avs_waitrequest);
endmodule : pss_status_summary_checker

// File: tb/pss_status_summary_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end
module pss_status_summary_test;
	logic        core_clk, reset, clk_en, avs_read, avs_write, avs_waitrequest, irq;
	logic [7:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0]  avs_byteenable;
	logic        rx_error_event, false_carrier_event, polarity_inverted, page_received_event;
	logic        interrupt_event, remote_fault_event, crossover_auto_state;
	logic        signal_detect, descrambler_lock;
	int          err_total, tests_run;

	pss_status_summary u_pss_status_summary (
		.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.rx_error_event(rx_error_event), .false_carrier_event(false_carrier_event),
		.polarity_inverted(polarity_inverted), .page_received_event(page_received_event),
		.interrupt_event(interrupt_event), .remote_fault_event(remote_fault_event),
		.crossover_auto_state(crossover_auto_state), .signal_detect(signal_detect),
		.descrambler_lock(descrambler_lock), .irq(irq)
	);

	always #12.5 core_clk = ~core_clk;

	// ****
	// bus and stimulus helpers
	// ****
	// entered just after an edge; leaves one idle edge so strobes never toggle twice
	task automatic xfer(input logic wr, input logic [5:0] idx, input logic [15:0] wd,
			output logic [15:0] rd);
		int n;
		n = 0;
		avs_address <= {idx, 2'b00};
		avs_writedata <= {16'h0000, wd};
		avs_read <= ~wr;
		avs_write <= wr;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		`CHK("waitrequest", 1'b0, avs_waitrequest)
		`CHK("readdata_upper", 16'h0000, avs_readdata[31:16])
		rd = avs_readdata[15:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk);
	endtask : xfer

	task automatic wr_reg(input logic [5:0] idx, input logic [15:0] wd);
		logic [15:0] d;
		xfer(1'b1, idx, wd, d);
	endtask : wr_reg

	task automatic rd_chk(input string nm, input logic [5:0] idx, input logic [15:0] mask,
			input logic [15:0] exp);
		logic [15:0] d;
		xfer(1'b0, idx, 16'h0000, d);
		`CHK(nm, exp & mask, d & mask)
	endtask : rd_chk

	task automatic fire(input logic [5:0] ev);
		{rx_error_event, false_carrier_event, polarity_inverted, page_received_event,
			interrupt_event, remote_fault_event} <= ev;
		@(posedge core_clk);
		{rx_error_event, false_carrier_event, polarity_inverted, page_received_event,
			interrupt_event, remote_fault_event} <= 6'h00;
	endtask : fire

	// synchroniser plus filter needs a few cycles, twelve leaves margin
	task automatic blip(input logic sd, input logic dl);
		signal_detect <= ~sd;
		descrambler_lock <= ~dl;
		repeat (12) @(posedge core_clk);
		signal_detect <= 1'b1;
		descrambler_lock <= 1'b1;
		repeat (12) @(posedge core_clk);
	endtask : blip

	// ****
	// scenarios
	// ****
	task automatic t_reset;
		rd_chk("summary_rst", 6'h10, 16'hFFFF, 16'h0000);
		rd_chk("control_rst", 6'h1D, 16'hFFFF, 16'h0000);
		rd_chk("mask_rst", 6'h1F, 16'hFFFF, 16'h0000);
		wr_reg(6'h10, 16'hFFFF);
		rd_chk("summary_ro", 6'h10, 16'hFFFF, 16'h0000);
		wr_reg(6'h20, 16'hFFFF);
		rd_chk("unmapped", 6'h20, 16'hFFFF, 16'h0000);
	endtask : t_reset

	task automatic t_latches;
		logic [5:0]  ci [6] = '{6'h15, 6'h14, 6'h1C, 6'h06, 6'h12, 6'h01};
		logic [15:0] cd [6] = '{16'h0000, 16'h0000, 16'h0010, 16'h0002, 16'h0000, 16'h0000};
		int          bn [6] = '{13, 11, 12, 8, 7, 6};
		logic [15:0] exp;
		fire(6'h3F);
		exp = 16'h39C0;
		rd_chk("summary_set", 6'h10, 16'hB9C0, exp);
		rd_chk("summary_keep", 6'h10, 16'hB9C0, exp);
		for (int k = 0; k < 6; k++) begin
			rd_chk("source_reg", ci[k], 16'hFFFF, cd[k]);
			exp = exp & ~(16'h0001 << bn[k]);
			rd_chk("summary_clr", 6'h10, 16'hB9C0, exp);
		end
		// event while frozen must not land
		clk_en <= 1'b0;
		rx_error_event <= 1'b1;
		@(posedge core_clk);
		clk_en <= 1'b1;
		rx_error_event <= 1'b0;
		@(posedge core_clk);
		rd_chk("summary_frozen", 6'h10, 16'h2000, 16'h0000);
	endtask : t_latches

	task automatic t_latch_low;
		signal_detect <= 1'b1;
		descrambler_lock <= 1'b1;
		repeat (12) @(posedge core_clk);
		rd_chk("detect_held", 6'h10, 16'h0600, 16'h0000);
		rd_chk("detect_up", 6'h10, 16'h0600, 16'h0600);
		blip(1'b1, 1'b0);
		rd_chk("detect_loss", 6'h10, 16'h0600, 16'h0200);
		rd_chk("detect_rearm", 6'h10, 16'h0600, 16'h0600);
		blip(1'b0, 1'b1);
		rd_chk("lock_loss", 6'h10, 16'h0600, 16'h0400);
		rd_chk("lock_rearm", 6'h10, 16'h0600, 16'h0600);
	endtask : t_latch_low

	task automatic t_crossover;
		crossover_auto_state <= 1'b1;
		wr_reg(6'h1D, 16'h0000);
		rd_chk("xover_off", 6'h10, 16'h4000, 16'h0000);
		wr_reg(6'h1D, 16'h0001);
		rd_chk("xover_swapped", 6'h10, 16'h4000, 16'h4000);
		crossover_auto_state <= 1'b0;
		@(posedge core_clk);
		rd_chk("xover_normal", 6'h10, 16'h4000, 16'h0000);
		wr_reg(6'h1D, 16'h0003);
		rd_chk("xover_forced", 6'h10, 16'h4000, 16'h4000);
		rd_chk("control_rw", 6'h1D, 16'hFFFF, 16'h0003);
		wr_reg(6'h1D, 16'h0000);
	endtask : t_crossover

	task automatic t_irq;
		wr_reg(6'h1E, 16'h003F);
		rd_chk("irq_w1c_all", 6'h1E, 16'h003F, 16'h0000);
		fire(6'h21);
		@(posedge core_clk);
		`CHK("irq_masked", 1'b0, irq)
		rd_chk("irq_status", 6'h1E, 16'h003F, 16'h0009);
		wr_reg(6'h1F, 16'h0001);
		`CHK("irq_on", 1'b1, irq)
		wr_reg(6'h1E, 16'h0001);
		`CHK("irq_off", 1'b0, irq)
		rd_chk("irq_left", 6'h1E, 16'h003F, 16'h0008);
	endtask : t_irq

	task automatic t_mid_reset;
		fire(6'h3F);
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		`CHK("irq_reset", 1'b0, irq)
		rd_chk("summary_mid_rst", 6'h10, 16'hFFC0, 16'h0000);
	endtask : t_mid_reset

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stop_test

	initial begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		stop_test();
	end

	initial begin
		core_clk = 1'b0;
		reset = 1'b1;
		clk_en = 1'b1;
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		avs_byteenable = 4'hF;
		{rx_error_event, false_carrier_event, polarity_inverted, page_received_event} = '0;
		{interrupt_event, remote_fault_event, crossover_auto_state} = '0;
		{signal_detect, descrambler_lock} = '0;
		err_total = 0;
		tests_run = 0;
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		t_reset();
		t_latches();
		t_latch_low();
		t_crossover();
		t_irq();
		t_mid_reset();
		stop_test();
	end
endmodule : pss_status_summary_test

bind pss_status_summary pss_status_summary_checker u_pss_status_summary_checker (
	.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .rx_error_event(rx_error_event),
	.false_carrier_event(false_carrier_event), .polarity_inverted(polarity_inverted),
	.page_received_event(page_received_event), .interrupt_event(interrupt_event),
	.remote_fault_event(remote_fault_event), .signal_detect(signal_detect),
	.descrambler_lock(descrambler_lock), .irq(irq)
);
